// ### hdl/sqd_command_logic.sv
// Command interpreter for a four-channel squib driver: timing clears,
// thermal status latch, arm/fire gating and driver transistor tests.
// Assumes asynchronous pins from the microcontroller and the analog side.
`timescale 1ns/1ps

// What this block does
// - Command 3X clears timing register of each channel whose bit is one.
// - Thermal status bit reads one while that driver is over its limit.
// - Command 7F captures thermal bits into a latch held for sending.
// - Thermal latch clears at chip-select rise of the next valid command.
// - Thermal trip acts per channel and only after the minimum on-time.
// - Arm/fire refuses at the command any driver whose thermal status is one.
// - Transistor test needs unlock byte then test byte as two writes.
// - Unlock byte accepted only while both fire permit inputs are low.
// - Accepted unlock byte is echoed on data out during next transfer.
// - Any enabled firing aborts a running transistor test.
// - Unlock suspends other diagnostics until the second write completes.
// - Unlock 82 then 1X tests the selected high-side drivers.
// - Unlock 83 then 2X tests the selected low-side drivers.
// - Tests are not timed; a later serial command ends them.
// - Either unlock byte immediately stops any test in progress.
// - Successive test commands may exercise any driver combination.
// - Test fail bit is one if the driver did not turn on, else zero.
// - Test status shifts out during the transfer after the test command.
// - Test status register clears when an unlock byte is loaded.
// - Low permit input blocks firing of its channels; diagnostics remain.
// - Reset low clears all state, activation and tests.
module sqd_command_logic
	import sqd_pkg::*;
#(
	parameter int unsigned ON_MIN_CYC = sqd_pkg::THERM_MIN_CYC
)
(
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     cs_n_i,
	input  wire logic                     sclk_i,
	input  wire logic                     mosi_i,
	input  wire logic                     fire_permit_in_one_i,
	input  wire logic                     fire_permit_in_two_i,
	input  wire logic [sqd_pkg::CH_N-1:0] thermal_trip_i,
	input  wire logic [sqd_pkg::CH_N-1:0] hs_on_sense_i,
	input  wire logic [sqd_pkg::CH_N-1:0] ls_on_sense_i,
	output logic                          miso_o,
	output logic                          miso_oe_o,
	output logic      [sqd_pkg::CH_N-1:0] hs_drive_o,
	output logic      [sqd_pkg::CH_N-1:0] ls_drive_o,
	output logic                          test_current_o,
	output logic      [sqd_pkg::CH_N-1:0] timing_clear_o,
	output logic                          diag_hold_o
);
	import sqd_pkg::*;

	localparam int unsigned SW = 2 + 3 * CH_N;
	localparam int unsigned CW = $clog2(ON_MIN_CYC + 1);
	localparam logic [CW-1:0] ON_MAX = CW'(ON_MIN_CYC);

	logic [SW-1:0]     sy_a;
	logic [SW-1:0]     sy_b;
	logic [1:0]        permit;
	logic [CH_N-1:0]   therm_stat;
	logic [CH_N-1:0]   hs_sense;
	logic [CH_N-1:0]   ls_sense;
	logic [BYTE_W-1:0] rx_byte;
	logic              frame_ok;
	logic [BYTE_W-1:0] tx_byte;
	logic [BYTE_W-1:0] echo_byte;
	logic [1:0]        reply_sel;
	logic [CH_N-1:0]   therm_latch;
	logic [CH_N-1:0]   fire_cmd;
	logic [CH_N-1:0]   fire_on;
	logic [CH_N-1:0]   on_done;
	logic [CW-1:0]     on_cnt [CH_N];
	sqd_test_e         test_st;
	logic [CH_N-1:0]   hs_test;
	logic [CH_N-1:0]   ls_test;
	logic [BYTE_W-1:0] test_fail;
	logic              unlock_ok;
	logic              cmd_ok;
	logic              permit_any;

	// Frame reception and reply shifting.
	sqd_serial_port sqd_serial_port_i (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.cs_n_i     (cs_n_i),
		.sclk_i     (sclk_i),
		.mosi_i     (mosi_i),
		.tx_byte_i  (tx_byte),
		.rx_byte_o  (rx_byte),
		.frame_ok_o (frame_ok),
		.miso_o     (miso_o),
		.miso_oe_o  (miso_oe_o)
	);

	// Analog flags and permit pins are asynchronous, so they pass two flops.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sy_a <= '0;
			sy_b <= '0;
		end
		else
		begin
			sy_a <= {ls_on_sense_i, hs_on_sense_i, thermal_trip_i,
				fire_permit_in_two_i, fire_permit_in_one_i};
			sy_b <= sy_a;
		end
	end

	// Thermal status follows the trip flag of each driver.
	assign permit     = sy_b[1:0];
	assign therm_stat = sy_b[2+:CH_N];
	assign hs_sense   = sy_b[2+CH_N+:CH_N];
	assign ls_sense   = sy_b[2+2*CH_N+:CH_N];
	assign permit_any = |permit;

	// Unlock is the decode ANDed with both permits low.
	assign unlock_ok = frame_ok && ((rx_byte == CMD_UNL_HS) || (rx_byte == CMD_UNL_LS))
		&& !permit_any;
	// Other diagnostics run only while no unlock is pending.
	assign cmd_ok = frame_ok && (test_st == T_IDLE);

	// Timing clear pulses, one cycle, per selected channel.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			timing_clear_o <= NIB_RST;
		else if (cmd_ok && (rx_byte[7:4] == OP_CLR_TIMING))
			timing_clear_o <= rx_byte[3:0];
		else
			timing_clear_o <= NIB_RST;
	end

	// Thermal latch: any valid command clears it, a new 7F recaptures.
	// The capture wins over the clear, so a back-to-back query loses nothing.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			therm_latch <= NIB_RST;
		else if (cmd_ok && (rx_byte == CMD_THERM))
			therm_latch <= therm_stat;
		else if (frame_ok)
			therm_latch <= NIB_RST;
	end

	// Arm/fire register; hot channels are refused at the command.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			fire_cmd <= NIB_RST;
		else if (cmd_ok && (rx_byte[7:4] == OP_ARM_FIRE))
			fire_cmd <= rx_byte[3:0] & ~therm_stat;
	end

	// Per channel on-time counter; a trip shuts only its own channel, and
	// only after the minimum on-time, so a brief flag cannot cut a firing.
	for (genvar i = 0; i < CH_N; i++)
	begin : g_ch
		assign on_done[i] = (on_cnt[i] == ON_MAX);
		assign fire_on[i] = fire_cmd[i] && permit[i/2]
			&& !(therm_stat[i] && on_done[i]);

		always_ff @(posedge core_clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				on_cnt[i] <= '0;
			else if (!(fire_cmd[i] && permit[i/2]))
				on_cnt[i] <= '0;
			else if (!on_done[i])
				on_cnt[i] <= on_cnt[i] + CW'(1);
		end
	end

	// Test sequencer: unlock, then one test byte, then back to idle.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			test_st <= T_IDLE;
			hs_test <= NIB_RST;
			ls_test <= NIB_RST;
		end
		else if (permit_any)
		begin
			// Enabling any fire path must never meet a test drive.
			test_st <= T_IDLE;
			hs_test <= NIB_RST;
			ls_test <= NIB_RST;
		end
		else if (unlock_ok)
		begin
			test_st <= (rx_byte == CMD_UNL_HS) ? T_HS_UNL : T_LS_UNL;
			hs_test <= NIB_RST;
			ls_test <= NIB_RST;
		end
		else if (frame_ok)
		begin
			test_st <= T_IDLE;
			hs_test <= NIB_RST;
			ls_test <= NIB_RST;
			case (test_st)
				T_HS_UNL:
					if (rx_byte[7:4] == OP_HS_TEST)
						hs_test <= rx_byte[3:0];
				T_LS_UNL:
					if (rx_byte[7:4] == OP_LS_TEST)
						ls_test <= rx_byte[3:0];
				default:
					test_st <= T_IDLE;
			endcase
		end
	end

	// Test status: low nibble high side, high nibble low side; only tested
	// channels update, and each accepted unlock byte clears the whole register.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			test_fail <= BYTE_RST;
		else if (unlock_ok)
			test_fail <= BYTE_RST;
		else
		begin
			for (int k = 0; k < CH_N; k++)
			begin
				if (hs_test[k])
					test_fail[k] <= !hs_sense[k];
				if (ls_test[k])
					test_fail[CH_N+k] <= !ls_sense[k];
			end
		end
	end

	// Reply source for the next transfer, chosen by the last command.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reply_sel <= SEL_NONE;
			echo_byte <= BYTE_RST;
		end
		else if (unlock_ok)
		begin
			reply_sel <= SEL_ECHO;
			echo_byte <= rx_byte;
		end
		else if (frame_ok && (test_st != T_IDLE))
			reply_sel <= SEL_TEST;
		else if (cmd_ok && (rx_byte == CMD_THERM))
			reply_sel <= SEL_THERM;
		else if (frame_ok)
			reply_sel <= SEL_NONE;
	end

	// Reply byte is refreshed every cycle; the port samples it at select fall.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tx_byte <= BYTE_RST;
		else
		begin
			case (reply_sel)
				SEL_ECHO:  tx_byte <= echo_byte;
				SEL_THERM: tx_byte <= {NIB_RST, therm_latch};
				SEL_TEST:  tx_byte <= test_fail;
				default:   tx_byte <= BYTE_RST;
			endcase
		end
	end

	// Driver outputs; test drive uses the reduced current limit.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hs_drive_o     <= NIB_RST;
			ls_drive_o     <= NIB_RST;
			test_current_o <= 1'b0;
			diag_hold_o    <= 1'b0;
		end
		else
		begin
			hs_drive_o     <= fire_on | hs_test;
			ls_drive_o     <= fire_on | ls_test;
			test_current_o <= |{hs_test, ls_test};
			diag_hold_o    <= (test_st != T_IDLE);
		end
	end

	// Checks on the command behaviour.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_unlock;
		unlock_ok;
	endsequence

	sequence s_hs_cmd;
		frame_ok && (test_st == T_HS_UNL) && !permit_any && (rx_byte[7:4] == OP_HS_TEST);
	endsequence

	property p_clear_sel;
		cmd_ok && (rx_byte[7:4] == OP_CLR_TIMING) |=> timing_clear_o == $past(rx_byte[3:0]);
	endproperty
	a_clear_sel: assert property (p_clear_sel) else $error("timing clear mask wrong");

	property p_therm_cap;
		cmd_ok && (rx_byte == CMD_THERM) |=> therm_latch == $past(therm_stat);
	endproperty
	a_therm_cap: assert property (p_therm_cap) else $error("thermal latch not captured");

	property p_therm_clr;
		frame_ok && (rx_byte != CMD_THERM) |=> therm_latch == NIB_RST;
	endproperty
	a_therm_clr: assert property (p_therm_clr) else $error("thermal latch not cleared");

	property p_arm_cool;
		cmd_ok && (rx_byte[7:4] == OP_ARM_FIRE) |=> (fire_cmd & $past(therm_stat)) == NIB_RST;
	endproperty
	a_arm_cool: assert property (p_arm_cool) else $error("hot driver armed");

	property p_unlock_permit;
		(test_st != T_IDLE) && ($past(test_st) == T_IDLE) |-> $past(permit) == 2'h0;
	endproperty
	a_unlock_permit: assert property (p_unlock_permit) else $error("unlock with permit");

	property p_abort;
		permit_any |=> ##1 ((hs_drive_o | ls_drive_o) & ~$past(fire_cmd)) == NIB_RST
			&& !test_current_o;
	endproperty
	a_abort: assert property (p_abort) else $error("test not aborted");

	property p_unlock_stop;
		s_unlock |=> hs_test == NIB_RST && ls_test == NIB_RST && test_fail == BYTE_RST
			##1 !test_current_o && diag_hold_o;
	endproperty
	a_unlock_stop: assert property (p_unlock_stop) else $error("unlock did not stop test");

	property p_echo;
		s_unlock |=> ##1 tx_byte == $past(rx_byte, 2);
	endproperty
	a_echo: assert property (p_echo) else $error("unlock not echoed");

	property p_hs_start;
		s_hs_cmd |=> hs_test == $past(rx_byte[3:0]) && test_st == T_IDLE
			##1 hs_drive_o == hs_test;
	endproperty
	a_hs_start: assert property (p_hs_start) else $error("high side test not started");

	property p_no_lone_test;
		frame_ok && (test_st == T_IDLE) |=> hs_test == NIB_RST && ls_test == NIB_RST;
	endproperty
	a_no_lone_test: assert property (p_no_lone_test) else $error("test ran without unlock");

endmodule

// ### hdl/sqd_pkg.sv
// Shared constants for the squib diagnostic command logic.
// Assumes a 20 MHz core clock and 8-bit serial command frames.
package sqd_pkg;

	// Channel count; bit 0 to 3 of a nibble map to 1A, 1B, 2A, 2B.
	localparam int unsigned CH_N = 4;
	localparam int unsigned BYTE_W = 8;

	// Command bytes and upper-nibble opcodes.
	localparam logic [3:0] OP_CLR_TIMING = 4'h3;
	localparam logic [3:0] OP_HS_TEST    = 4'h1;
	localparam logic [3:0] OP_LS_TEST    = 4'h2;
	localparam logic [3:0] OP_ARM_FIRE   = 4'h4;
	localparam logic [7:0] CMD_THERM     = 8'h7F;
	localparam logic [7:0] CMD_UNL_HS    = 8'h82;
	localparam logic [7:0] CMD_UNL_LS    = 8'h83;

	// Reply source selects for the next transfer.
	localparam logic [1:0] SEL_NONE  = 2'h0;
	localparam logic [1:0] SEL_ECHO  = 2'h1;
	localparam logic [1:0] SEL_THERM = 2'h2;
	localparam logic [1:0] SEL_TEST  = 2'h3;

	// Reset values.
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] NIB_RST  = 4'h0;

	// Frame is valid with exactly this many clock edges.
	localparam logic [3:0] FRAME_BITS = 4'h8;

	// Least driver on-time before a thermal trip may act.
	localparam int unsigned CLK_MHZ       = 20;
	localparam int unsigned THERM_MIN_US  = 2090;
	localparam int unsigned THERM_MIN_CYC = THERM_MIN_US * CLK_MHZ;

	// Transistor test sequencer states.
	typedef enum logic [1:0] {T_IDLE, T_HS_UNL, T_LS_UNL} sqd_test_e;

endpackage

// ### hdl/sqd_serial_port.sv
// Serial frame port: synchronises the chip select, clock and data pins,
// shifts an 8-bit command in and a reply byte out. Mode 0 framing.
`timescale 1ns/1ps

module sqd_serial_port
	import sqd_pkg::*;
(
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       cs_n_i,
	input  wire logic                       sclk_i,
	input  wire logic                       mosi_i,
	input  wire logic [sqd_pkg::BYTE_W-1:0] tx_byte_i,
	output logic      [sqd_pkg::BYTE_W-1:0] rx_byte_o,
	output logic                            frame_ok_o,
	output logic                            miso_o,
	output logic                            miso_oe_o
);
	import sqd_pkg::*;

	logic [2:0]        sy_a;
	logic [2:0]        sy_b;
	logic [2:0]        sy_c;
	logic [BYTE_W-1:0] sh_rx;
	logic [BYTE_W-1:0] sh_tx;
	logic [3:0]        bit_cnt;
	logic              cs_fall;
	logic              cs_rise;
	logic              clk_rise;
	logic              clk_fall;

	// Two-stage synchroniser; the third stage only serves edge detection.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sy_a <= 3'h1;
			sy_b <= 3'h1;
			sy_c <= 3'h1;
		end
		else
		begin
			sy_a <= {mosi_i, sclk_i, cs_n_i};
			sy_b <= sy_a;
			sy_c <= sy_b;
		end
	end

	// Edges seen on the synchronised copies only.
	assign cs_fall  = !sy_b[0] && sy_c[0];
	assign cs_rise  = sy_b[0] && !sy_c[0];
	assign clk_rise = !sy_b[0] && sy_b[1] && !sy_c[1];
	assign clk_fall = !sy_b[0] && !sy_b[1] && sy_c[1];

	// Receive shift and bit count; the count saturates so long frames fail.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sh_rx   <= BYTE_RST;
			bit_cnt <= NIB_RST;
		end
		else if (cs_fall)
		begin
			bit_cnt <= NIB_RST;
		end
		else if (clk_rise)
		begin
			sh_rx <= {sh_rx[BYTE_W-2:0], sy_b[2]};
			if (bit_cnt != 4'hF)
				bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// A frame counts only when exactly eight bits arrived before the rise.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_byte_o  <= BYTE_RST;
			frame_ok_o <= 1'b0;
		end
		else
		begin
			frame_ok_o <= cs_rise && (bit_cnt == FRAME_BITS);
			if (cs_rise && (bit_cnt == FRAME_BITS))
				rx_byte_o <= sh_rx;
		end
	end

	// Reply byte is captured at select fall and moved on each falling clock.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sh_tx     <= BYTE_RST;
			miso_o    <= 1'b0;
			miso_oe_o <= 1'b0;
		end
		else if (cs_fall)
		begin
			sh_tx     <= tx_byte_i;
			miso_o    <= tx_byte_i[BYTE_W-1];
			miso_oe_o <= 1'b1;
		end
		else if (cs_rise)
		begin
			miso_oe_o <= 1'b0;
		end
		else if (clk_fall)
		begin
			sh_tx  <= {sh_tx[BYTE_W-2:0], 1'b0};
			miso_o <= sh_tx[BYTE_W-2];
		end
	end

endmodule

// ### testbench/sqd_spi_master_model.sv
// Behavioural serial master standing where the microcontroller sits.
// Assumes mode 0 framing and a core clock shared with the bench.
`timescale 1ns/1ps

module sqd_spi_master_model
(
	input  wire logic                      core_clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      start_i,
	input  wire logic [sqd_pkg::BYTE_W-1:0] tx_byte_i,
	input  wire logic                      miso_i,
	input  wire logic                      miso_oe_i,
	output logic                           cs_n_o,
	output logic                           sclk_o,
	output logic                           mosi_o,
	output logic      [sqd_pkg::BYTE_W-1:0] rx_byte_o,
	output logic                           done_o
);
	import sqd_pkg::*;

	// Six core cycles per serial phase leave room for the pin synchronisers.
	localparam int HALF = 6;

	logic                miso_last = 1'b0;
	logic                miso_line;
	logic [BYTE_W-1:0]   sh;

	// A released data line shows the inverse of its last level, never a copy.
	always @(posedge core_clk_i)
	begin
		if (miso_oe_i)
			miso_last <= miso_i;
	end
	assign miso_line = miso_oe_i ? miso_i : ~miso_last;

	// One whole byte per frame; the serial clock stands low between frames.
	// A single process owns every output, so no value has two writers.
	initial
	begin
		cs_n_o    = 1'b1;
		sclk_o    = 1'b0;
		mosi_o    = 1'b0;
		rx_byte_o = 8'h00;
		done_o    = 1'b0;
		forever
		begin
			@(posedge core_clk_i);
			done_o <= 1'b0;
			if (rst_n_i && start_i)
			begin
				sh = tx_byte_i;
				cs_n_o <= 1'b0;
				for (int b = 0; b < 8; b++)
				begin
					mosi_o <= sh[7];
					repeat (HALF) @(posedge core_clk_i);
					sh = {sh[6:0], miso_line};
					sclk_o <= 1'b1;
					repeat (HALF) @(posedge core_clk_i);
					sclk_o <= 1'b0;
				end
				repeat (HALF) @(posedge core_clk_i);
				cs_n_o <= 1'b1;
				mosi_o <= ~mosi_o;
				rx_byte_o <= sh;
				done_o <= 1'b1;
			end
		end
	end
endmodule

// ### testbench/squib_diag_command_logic_tb_top.sv
// Self-checking bench for the squib command logic with a serial master model.
// Assumes the design package is compiled first; runs at 20 MHz.
`timescale 1ns/1ps

module squib_diag_command_logic_tb_top;
	import sqd_pkg::*;

	logic            clk, rst_n, start, done, cs_n, sclk, mosi, miso, miso_oe;
	logic            perm_one, perm_two, test_cur, diag_hold, clr_zero;
	logic [7:0]      tx, rx, next_rep, clr_cnt, exp_b;
	logic [3:0]      trip, hs_sense, ls_sense, hs_drv, ls_drv, clr, clr_seen, x, y;
	logic [7:0]      rep_q[$];
	int              bad_count, n_tests, cyc;

	sqd_command_logic #(.ON_MIN_CYC(20)) sqd_command_logic_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
		.mosi_i(mosi), .fire_permit_in_one_i(perm_one),
		.fire_permit_in_two_i(perm_two), .thermal_trip_i(trip),
		.hs_on_sense_i(hs_sense), .ls_on_sense_i(ls_sense), .miso_o(miso),
		.miso_oe_o(miso_oe), .hs_drive_o(hs_drv), .ls_drive_o(ls_drv),
		.test_current_o(test_cur), .timing_clear_o(clr), .diag_hold_o(diag_hold));

	sqd_spi_master_model sqd_spi_master_model_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .start_i(start), .tx_byte_i(tx),
		.miso_i(miso), .miso_oe_i(miso_oe), .cs_n_o(cs_n), .sclk_o(sclk),
		.mosi_o(mosi), .rx_byte_o(rx), .done_o(done));

	// The clock toggles every 25 ns.
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Sends one byte, notes the reply due now and what the next frame owes.
	task automatic frame(input logic [7:0] cmd, input logic [7:0] after);
		int n;
		rep_q.push_back(next_rep);
		next_rep = after;
		start <= 1'b1;
		tx <= cmd;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		// A frame that never finishes is a mismatch, not a silent skip.
		if (n >= 400)
		begin
			bad_count++;
			$display("[ERR] frame_done expected 1 seen 0");
		end
		repeat (10) @(posedge clk);
	endtask

	// Empties the clear-pulse gatherer one edge before the next frame.
	task automatic gather_reset();
		clr_zero <= 1'b1;
		@(posedge clk);
		clr_zero <= 1'b0;
	endtask

	// Every finished frame takes the oldest noted reply and compares it.
	always @(posedge clk)
	begin
		if (done === 1'b1)
		begin
			exp_b = (rep_q.size() > 0) ? rep_q.pop_front() : 8'hEE;
			check("reply", rx, exp_b);
		end
	end

	// Clear pulses are gathered so their mask and length can be judged later.
	// Only this process writes them; the bench asks for a restart via clr_zero.
	always @(posedge clk)
	begin
		if (!rst_n || clr_zero)
		begin
			clr_seen <= 4'h0;
			clr_cnt  <= 8'h00;
		end
		else
		begin
			clr_seen <= clr_seen | clr;
			if (clr != 4'h0)
				clr_cnt <= clr_cnt + 8'h01;
		end
	end

	// A hang is cut short well beyond the expected run length.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			$display("timeout reached");
			complete_run();
		end
	end

	initial
	begin
		{rst_n, start, perm_one, perm_two, clr_zero} = 5'h00;
		{tx, next_rep} = 16'h0000;
		{trip, hs_sense, ls_sense} = 12'h000;
		void'($urandom(32'h4864));
		repeat (5) @(posedge clk);
		check("rst_drive", {hs_drv, ls_drv}, 8'h00);
		check("rst_flags", {clr, miso_oe, test_cur, diag_hold, 1'b0}, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++)
		begin
			x = (i == 3) ? 4'hF : 4'($urandom_range(1, 14));
			gather_reset();
			frame({OP_CLR_TIMING, x}, 8'h00);
			check("clear_mask", {4'h0, clr_seen}, {4'h0, x});
			check("clear_len", clr_cnt, 8'h01);
		end
		$display("test clear done");
		x = 4'($urandom_range(1, 15));
		trip <= x;
		repeat (4) @(posedge clk);
		frame(CMD_THERM, {4'h0, x});
		trip <= 4'h0;
		frame(CMD_THERM, 8'h00);
		frame(8'h00, 8'h00);
		$display("test thermal done");
		trip <= 4'b0010;
		perm_one <= 1'b1;
		repeat (4) @(posedge clk);
		frame({OP_ARM_FIRE, 4'hF}, 8'h00);
		check("arm_pair_one", {4'h0, hs_drv}, 8'h01);
		perm_two <= 1'b1;
		repeat (6) @(posedge clk);
		check("arm_both", {4'h0, hs_drv}, 8'h0D);
		repeat (25) @(posedge clk);
		trip <= 4'b0011;
		repeat (6) @(posedge clk);
		check("thermal_trip", {4'h0, hs_drv}, 8'h0C);
		frame({OP_ARM_FIRE, 4'h0}, 8'h00);
		check("disarm", {4'h0, hs_drv}, 8'h00);
		{perm_one, perm_two} <= 2'b00;
		trip <= 4'h0;
		$display("test arm done");
		hs_sense <= 4'($urandom);
		ls_sense <= 4'($urandom);
		x = 4'($urandom_range(1, 15));
		y = 4'($urandom_range(1, 15));
		repeat (4) @(posedge clk);
		frame(CMD_UNL_HS, CMD_UNL_HS);
		check("hold_unlock", {7'h00, diag_hold}, 8'h01);
		frame({OP_HS_TEST, x}, {4'h0, x & ~hs_sense});
		repeat (30) @(posedge clk);
		check("hs_test", {4'h0, hs_drv}, {4'h0, x});
		check("hs_flags", {6'h00, test_cur, diag_hold}, 8'h02);
		frame(CMD_UNL_LS, CMD_UNL_LS);
		check("hs_stop", {hs_drv, ls_drv}, 8'h00);
		frame({OP_LS_TEST, y}, {y & ~ls_sense, 4'h0});
		check("ls_test", {4'h0, ls_drv}, {4'h0, y});
		perm_one <= 1'b1;
		repeat (6) @(posedge clk);
		check("abort", {3'h0, ls_drv, test_cur}, 8'h00);
		frame(CMD_UNL_HS, 8'h00);
		check("unlock_refused", {7'h00, diag_hold}, 8'h00);
		perm_one <= 1'b0;
		repeat (4) @(posedge clk);
		frame({OP_HS_TEST, 4'hF}, 8'h00);
		check("stray_test", {4'h0, hs_drv}, 8'h00);
		$display("test transistor done");
		frame(CMD_UNL_LS, CMD_UNL_LS);
		gather_reset();
		frame({OP_CLR_TIMING, 4'hF}, 8'h00);
		check("suspended", {4'h0, clr_seen}, 8'h00);
		gather_reset();
		frame({OP_CLR_TIMING, 4'hF}, 8'h00);
		check("resumed", {4'h0, clr_seen}, 8'h0F);
		frame(8'h00, 8'h00);
		check("queue_left", 8'(rep_q.size()), 8'h00);
		$display("test suspend done");
		complete_run();
	end
endmodule
